// *** bench/tb_top.sv ***
// Self-checking bench for the independent window watchdog
`timescale 1ns/1ps
module tb_top;
   logic        mclk_i       = 1'b0;
   logic        sys_rst_i    = 1'b1;
   logic        count_clk_i  = 1'b0;
   logic        auto_start_i = 1'b0;
   logic        sleep_i      = 1'b0;
   logic [4:0]  address_i    = 5'h00;
   logic        read_i       = 1'b0;
   logic        write_i      = 1'b0;
   logic [31:0] writedata_i  = 32'h0000_0000;
   logic [3:0]  byteenable_i = 4'h0;
   logic [31:0] readdata_o;
   logic        waitrequest_o;
   logic        reset_req_o;
   logic        irq_o;
   logic        evt_underflow_o;
   logic        evt_refresh_err_o;
   logic        sleep_count_stop_o;
   int          failures = 0;
   int          n_tests  = 0;
   int          n_rst = 0, n_irq = 0, n_uf = 0, n_re = 0;
   int          m_cnt, m_run, m_uf, m_re, m_st, m_en, m_ratio, m_pre, m_auto, m_rsel, m_slp;
   int          e_rst = 0, e_irq = 0, e_uf = 0, e_re = 0;
   int          st_pos[4] = '{32'h0fff, 32'h1fff, 32'h2fff, 32'h3fff};
   int          en_pos[4] = '{32'h2fff, 32'h1fff, 32'h0fff, 32'h0000};
   int          ratios[$] = '{16, 32, 64, 128, 256};
   logic [3:0]  codes[5]  = '{4'h2, 4'h3, 4'h4, 4'hf, 4'h5};

   always #4 mclk_i = ~mclk_i;

   iwwdt_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .count_clk_i(count_clk_i), .auto_start_i(auto_start_i),
      .sleep_i(sleep_i), .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .reset_req_o(reset_req_o), .irq_o(irq_o), .evt_underflow_o(evt_underflow_o),
      .evt_refresh_err_o(evt_refresh_err_o), .sleep_count_stop_o(sleep_count_stop_o));

   // ==========================================================
   // Pulse monitors: counting high cycles also catches a stuck output
   always @(posedge mclk_i) begin
      if (reset_req_o === 1'b1) n_rst <= n_rst + 1;
      if (irq_o === 1'b1) n_irq <= n_irq + 1;
      if (evt_underflow_o === 1'b1) n_uf <= n_uf + 1;
      if (evt_refresh_err_o === 1'b1) n_re <= n_re + 1;
   end

   // ==========================================================
   // Checking and closing
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Checks made %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // Avalon-MM master: hold until waitrequest sampled low
   task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      address_i    <= a;
      write_i      <= wr;
      read_i       <= ~wr;
      writedata_i  <= d;
      byteenable_i <= be;
      do begin
         @(posedge mclk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      q = readdata_o;
      read_i  <= 1'b0;
      write_i <= 1'b0;
      if (waitrequest_o !== 1'b0) begin
         failures++;
         close_out();
      end
      @(posedge mclk_i);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(a, 1'b1, d, be, q);
   endtask

   task automatic chk_rd(input string what, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0000_0000, 4'hf, q);
      chk(what, q, exp);
   endtask

   // ==========================================================
   // Model-backed stimulus
   task automatic chk_st();
      chk_rd("status", iwwdt_pkg::ADDR_STATUS, 32'((m_re << 15) | (m_uf << 14) | m_cnt));
   endtask

   task automatic chk_ev();
      chk("reset pulses", 32'(n_rst), 32'(e_rst));
      chk("irq pulses", 32'(n_irq), 32'(e_irq));
      chk("underflow pulses", 32'(n_uf), 32'(e_uf));
      chk("refresh error pulses", 32'(n_re), 32'(e_re));
   endtask

   task automatic do_reset(input logic a);
      sys_rst_i    <= 1'b1;
      auto_start_i <= a;
      repeat (4) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      m_cnt   = 16383;
      m_run   = a;
      m_auto  = a;
      m_uf    = 0;
      m_re    = 0;
      m_st    = 16383;
      m_en    = 0;
      m_ratio = 1;
      m_pre   = 0;
      m_rsel  = 0;
      m_slp   = 0;
   endtask

   // Count clock levels held 3 cycles each, one more than the 2 the sampler needs
   task automatic ticks(input int n);
      repeat (n) begin
         count_clk_i <= 1'b1;
         repeat (3) @(posedge mclk_i);
         count_clk_i <= 1'b0;
         repeat (3) @(posedge mclk_i);
         m_pre++;
         if (m_pre == m_ratio) begin
            m_pre = 0;
            if (m_run != 0 && !(m_slp != 0 && sleep_i === 1'b1)) begin
               if (m_cnt == 0) begin
                  m_cnt = 16383;
                  m_uf  = 1;
                  m_run = m_auto;
                  e_uf++;
                  if (m_rsel != 0) e_rst++;
                  else e_irq++;
               end else begin
                  m_cnt--;
               end
            end
         end
      end
      repeat (8) @(posedge mclk_i);
   endtask

   task automatic refresh();
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_0000, 4'h1);
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_00ff, 4'h1);
      if (m_run == 0) begin
         m_cnt = 16383;
         m_run = 1;
      end else if (m_cnt <= m_st && m_cnt >= m_en) begin
         m_cnt = 16383;
      end else begin
         m_cnt = 16383;
         m_run = 0;
         m_re  = 1;
         e_re++;
         if (m_rsel != 0) e_rst++;
         else e_irq++;
      end
   endtask

   task automatic set_ctl(input logic [3:0] code, input int r, input int s, input int e);
      wr(iwwdt_pkg::ADDR_CONTROL, 32'((s << 12) | (e << 8)) | {24'h0, code, 4'h0}, 4'h3);
      m_ratio = r;
      m_st    = st_pos[s];
      m_en    = en_pos[e];
   endtask

   // ==========================================================
   // Watchdog on the whole run
   initial begin
      repeat (200000) @(posedge mclk_i);
      failures++;
      close_out();
   end

   // ==========================================================
   // Main sequence
   initial begin
      int k;
      k = $urandom(1);
      do_reset(1'b0);
      chk_rd("control", iwwdt_pkg::ADDR_CONTROL, 32'h0000_3300);
      chk_st();
      chk_rd("reset select", iwwdt_pkg::ADDR_RESET_SEL, 32'h0000_0000);
      chk_rd("sleep stop", iwwdt_pkg::ADDR_SLEEP_STP, 32'h0000_0000);
      chk_rd("option", iwwdt_pkg::ADDR_OPTION, 32'h0000_0000);
      chk_rd("refresh", iwwdt_pkg::ADDR_REFRESH, 32'h0000_0000);
      chk_rd("unmapped", 5'h18, 32'h0000_0000);
      ticks(4);
      chk_st();
      // Lone second byte, then a sequence broken by a stray value
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_00ff, 4'h1);
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_0000, 4'h1);
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_0055, 4'h1);
      wr(iwwdt_pkg::ADDR_REFRESH, 32'h0000_00ff, 4'h1);
      ticks(3);
      chk_st();
      refresh();
      k = $urandom_range(12, 3);
      ticks(k);
      chk_st();
      foreach (codes[i]) begin
         set_ctl(codes[i], ratios[i], 3, 3);
         ticks(2 * ratios[i]);
         chk_st();
      end
      for (int e = 0; e < 4; e++) begin
         set_ctl(4'h0, 1, 3, e);
         ticks(2);
         refresh();
         chk_st();
      end
      for (int s = 0; s < 3; s++) begin
         set_ctl(4'h0, 1, s, 3);
         ticks(1);
         refresh();
         ticks(3);
         chk_st();
         wr(iwwdt_pkg::ADDR_STATUS, 32'h0000_0000, 4'h2);
         m_re = 0;
         refresh();
         chk_st();
      end
      chk_ev();
      wr(iwwdt_pkg::ADDR_SLEEP_STP, 32'h0000_0080, 4'h1);
      m_slp = 1;
      sleep_i <= 1'b1;
      ticks($urandom_range(6, 2));
      chk("sleep stop out", {31'h0, sleep_count_stop_o}, 32'h0000_0001);
      chk_st();
      sleep_i <= 1'b0;
      ticks(2);
      chk("sleep stop out", {31'h0, sleep_count_stop_o}, 32'h0000_0000);
      chk_st();
      // Second reset in mid-run, now in auto-start mode
      do_reset(1'b1);
      chk_rd("control", iwwdt_pkg::ADDR_CONTROL, 32'h0000_3300);
      chk_rd("option", iwwdt_pkg::ADDR_OPTION, 32'h0000_0001);
      ticks(5);
      chk_st();
      wr(iwwdt_pkg::ADDR_RESET_SEL, 32'h0000_0080, 4'h1);
      m_rsel = 1;
      ticks(16379);
      chk_st();
      ticks(2);
      chk_st();
      chk_ev();
      close_out();
   end
endmodule

// *** rtl/iwwdt_pkg.sv ***
// Constants, register map and types of the independent window watchdog
// Functional notes
// - Count clock prescaled by 1,16,32,64,128,256
// - 14-bit counter decrements once per prescaled tick
// - Auto-start mode counts right after reset release
// - Refresh is 00h then FFh; starts register mode
// - Reset restores counter and registers, counting stops
// - Underflow or refresh error stops the counter
// - Auto-start resumes after reset or issued request
// - Register-start resumes only on new refresh
// - Window start and end bound refresh-permitted span
// - Reset request on underflow or out-of-window refresh
// - Interrupt request may replace the reset request
// - Status register shows current counter value
// - Event pulses for underflow and refresh error
// - Reset, interrupt and sleep-stop control outputs
// - Divide codes 0,2,3,4,f,5; others prohibited
// - Window start select in control bits 13..12
// - Refresh error flag in status bit 15
package iwwdt_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [4:0] ADDR_REFRESH   = 5'h00;
   localparam logic [4:0] ADDR_CONTROL   = 5'h04;
   localparam logic [4:0] ADDR_STATUS    = 5'h08;
   localparam logic [4:0] ADDR_RESET_SEL = 5'h0c;
   localparam logic [4:0] ADDR_SLEEP_STP = 5'h10;
   localparam logic [4:0] ADDR_OPTION    = 5'h14;

   // ==========================================================
   // Field positions
   localparam int DIV_LSB       = 4;
   localparam int WEND_LSB      = 8;
   localparam int WSTART_LSB    = 12;
   localparam int UFLOW_BIT     = 14;
   localparam int REFERR_BIT    = 15;
   localparam int RSEL_BIT      = 7;
   localparam int SLPSTP_BIT    = 7;
   localparam int AUTO_BIT      = 0;

   // ==========================================================
   // Reset values
   localparam logic [3:0]  DIV_RESET    = 4'h0;
   localparam logic [1:0]  WEND_RESET   = 2'h3;
   localparam logic [1:0]  WSTART_RESET = 2'h3;
   localparam logic        RSEL_RESET   = 1'b0;
   localparam logic        SLPSTP_RESET = 1'b0;

   // ==========================================================
   // Counter and window positions
   localparam int          CNT_W    = 14;
   localparam logic [13:0] CNT_FULL = 14'h3fff;
   localparam logic [13:0] POS_0    = 14'h0000;
   localparam logic [13:0] POS_25   = 14'h0fff;
   localparam logic [13:0] POS_50   = 14'h1fff;
   localparam logic [13:0] POS_75   = 14'h2fff;
   localparam logic [13:0] POS_100  = 14'h3fff;

   // ==========================================================
   // Refresh bytes and divide codes
   localparam logic [7:0] REFRESH_FIRST  = 8'h00;
   localparam logic [7:0] REFRESH_SECOND = 8'hff;
   localparam logic [3:0] DIV_CODE_1     = 4'h0;
   localparam logic [3:0] DIV_CODE_16    = 4'h2;
   localparam logic [3:0] DIV_CODE_32    = 4'h3;
   localparam logic [3:0] DIV_CODE_64    = 4'h4;
   localparam logic [3:0] DIV_CODE_128   = 4'hf;
   localparam logic [3:0] DIV_CODE_256   = 4'h5;
   localparam logic [7:0] TERM_1         = 8'h00;
   localparam logic [7:0] TERM_16        = 8'h0f;
   localparam logic [7:0] TERM_32        = 8'h1f;
   localparam logic [7:0] TERM_64        = 8'h3f;
   localparam logic [7:0] TERM_128       = 8'h7f;
   localparam logic [7:0] TERM_256       = 8'hff;

   typedef enum logic [1:0] {
      ST_STOP = 2'b01,
      ST_RUN  = 2'b10
   } iwwdt_state_t;

endpackage

// *** rtl/iwwdt_prescaler.sv ***
// Prescaler that divides dedicated count clock ticks into counter ticks
`timescale 1ns/1ps
module iwwdt_prescaler (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       src_tick_i,
   input  wire logic [3:0] divide_select_i,
   output logic            tick_o
);

   logic [7:0] div_cnt_reg;
   logic [7:0] term_w;
   logic       wrap_w;

   // ==========================================================
   // Ratio decode; prohibited codes fall back to no division
   assign term_w = (divide_select_i == iwwdt_pkg::DIV_CODE_16)  ? iwwdt_pkg::TERM_16  :
                   (divide_select_i == iwwdt_pkg::DIV_CODE_32)  ? iwwdt_pkg::TERM_32  :
                   (divide_select_i == iwwdt_pkg::DIV_CODE_64)  ? iwwdt_pkg::TERM_64  :
                   (divide_select_i == iwwdt_pkg::DIV_CODE_128) ? iwwdt_pkg::TERM_128 :
                   (divide_select_i == iwwdt_pkg::DIV_CODE_256) ? iwwdt_pkg::TERM_256 :
                                                                  iwwdt_pkg::TERM_1;
   // Greater-or-equal so a ratio change never strands the count
   assign wrap_w = (div_cnt_reg >= term_w);

   // ==========================================================
   // Divider
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div_cnt_reg <= 8'h00;
         tick_o      <= 1'b0;
      end else begin
         tick_o <= src_tick_i & wrap_w;
         if (src_tick_i) begin
            div_cnt_reg <= wrap_w ? 8'h00 : div_cnt_reg + 8'h01;
         end
      end
   end

endmodule

// *** rtl/iwwdt_top.sv ***
// Independent window watchdog: counter, refresh, window and Avalon-MM registers
`timescale 1ns/1ps
module iwwdt_top (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        count_clk_i,
   input  wire logic        auto_start_i,
   input  wire logic        sleep_i,
   input  wire logic [4:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   output logic             reset_req_o,
   output logic             irq_o,
   output logic             evt_underflow_o,
   output logic             evt_refresh_err_o,
   output logic             sleep_count_stop_o
);

   iwwdt_pkg::iwwdt_state_t state_reg;
   iwwdt_pkg::iwwdt_state_t state_next;

   logic [13:0] count_reg;
   logic [13:0] count_next;
   logic [3:0]  div_sel_reg;
   logic [1:0]  wend_reg;
   logic [1:0]  wstart_reg;
   logic        rsel_reg;
   logic        slpstp_reg;
   logic        auto_reg;
   logic        armed_reg;
   logic        uflow_flag_reg;
   logic        referr_flag_reg;
   logic        sync1_reg;
   logic        sync2_reg;
   logic        sync3_reg;
   logic        filt_reg;
   logic        src_tick_reg;
   logic        cnt_tick_w;

   // ==========================================================
   // Dedicated count clock: three-stage sampling, edge on agreement
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sync1_reg    <= 1'b0;
         sync2_reg    <= 1'b0;
         sync3_reg    <= 1'b0;
         filt_reg     <= 1'b0;
         src_tick_reg <= 1'b0;
      end else begin
         sync1_reg    <= count_clk_i;
         sync2_reg    <= sync1_reg;
         sync3_reg    <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            filt_reg <= sync2_reg;
         end
         src_tick_reg <= (sync2_reg == sync3_reg) & sync2_reg & ~filt_reg;
      end
   end

   iwwdt_prescaler u_prescaler (
      .mclk_i          (mclk_i),
      .sys_rst_i       (sys_rst_i),
      .src_tick_i      (src_tick_reg),
      .divide_select_i (div_sel_reg),
      .tick_o          (cnt_tick_w)
   );

   // ==========================================================
   // Bus decode
   wire        bus_go_w    = ~waitrequest_o & (read_i | write_i);
   wire        wr_go_w     = ~waitrequest_o & write_i;
   wire        hit_ref_w   = (address_i == iwwdt_pkg::ADDR_REFRESH);
   wire        hit_ctl_w   = (address_i == iwwdt_pkg::ADDR_CONTROL);
   wire        hit_sts_w   = (address_i == iwwdt_pkg::ADDR_STATUS);
   wire        hit_rsel_w  = (address_i == iwwdt_pkg::ADDR_RESET_SEL);
   wire        hit_slp_w   = (address_i == iwwdt_pkg::ADDR_SLEEP_STP);
   wire        hit_opt_w   = (address_i == iwwdt_pkg::ADDR_OPTION);
   wire        wr_ref_w    = wr_go_w & hit_ref_w & byteenable_i[0];
   wire [7:0]  wbyte_w     = writedata_i[7:0];

   // ==========================================================
   // Refresh sequence and window
   wire        refresh_hit_w = wr_ref_w & armed_reg & (wbyte_w == iwwdt_pkg::REFRESH_SECOND);
   wire        running_w     = (state_reg == iwwdt_pkg::ST_RUN);
   wire [13:0] win_start_w   = (wstart_reg == 2'h0) ? iwwdt_pkg::POS_25 :
                               (wstart_reg == 2'h1) ? iwwdt_pkg::POS_50 :
                               (wstart_reg == 2'h2) ? iwwdt_pkg::POS_75 : iwwdt_pkg::POS_100;
   wire [13:0] win_end_w     = (wend_reg == 2'h0) ? iwwdt_pkg::POS_75 :
                               (wend_reg == 2'h1) ? iwwdt_pkg::POS_50 :
                               (wend_reg == 2'h2) ? iwwdt_pkg::POS_25 : iwwdt_pkg::POS_0;
   wire        in_window_w   = (count_reg <= win_start_w) & (count_reg >= win_end_w);
   wire        refresh_err_w = refresh_hit_w & running_w & ~in_window_w;
   wire        refresh_ok_w  = refresh_hit_w & ~refresh_err_w;
   wire        sleep_stop_w  = slpstp_reg & sleep_i;
   wire        dec_en_w      = running_w & cnt_tick_w & ~sleep_stop_w;
   wire        underflow_w   = dec_en_w & (count_reg == iwwdt_pkg::POS_0) & ~refresh_hit_w;
   wire        fault_w       = underflow_w | refresh_err_w;

   // ==========================================================
   // Counter state machine
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      unique case (state_reg)
         iwwdt_pkg::ST_STOP: begin
            if (refresh_hit_w | auto_reg) begin
               state_next = iwwdt_pkg::ST_RUN;
               count_next = iwwdt_pkg::CNT_FULL;
            end
         end
         iwwdt_pkg::ST_RUN: begin
            if (fault_w) begin
               state_next = iwwdt_pkg::ST_STOP;
               count_next = iwwdt_pkg::CNT_FULL;
            end else if (refresh_ok_w) begin
               count_next = iwwdt_pkg::CNT_FULL;
            end else if (dec_en_w) begin
               count_next = count_reg - 14'h0001;
            end
         end
         default: begin
            state_next = iwwdt_pkg::ST_STOP;
            count_next = iwwdt_pkg::CNT_FULL;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_reg <= iwwdt_pkg::ST_STOP;
         count_reg <= iwwdt_pkg::CNT_FULL;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // ==========================================================
   // Refresh arming: any other refresh-register write disarms
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         armed_reg <= 1'b0;
      end else if (wr_ref_w) begin
         armed_reg <= (wbyte_w == iwwdt_pkg::REFRESH_FIRST);
      end
   end

   // ==========================================================
   // Software registers; the mode strap is caught while reset is held
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div_sel_reg <= iwwdt_pkg::DIV_RESET;
         wend_reg    <= iwwdt_pkg::WEND_RESET;
         wstart_reg  <= iwwdt_pkg::WSTART_RESET;
         rsel_reg    <= iwwdt_pkg::RSEL_RESET;
         slpstp_reg  <= iwwdt_pkg::SLPSTP_RESET;
         auto_reg    <= auto_start_i;
      end else begin
         if (wr_go_w & hit_ctl_w & byteenable_i[0]) begin
            div_sel_reg <= writedata_i[iwwdt_pkg::DIV_LSB +: 4];
         end
         if (wr_go_w & hit_ctl_w & byteenable_i[1]) begin
            wend_reg   <= writedata_i[iwwdt_pkg::WEND_LSB +: 2];
            wstart_reg <= writedata_i[iwwdt_pkg::WSTART_LSB +: 2];
         end
         if (wr_go_w & hit_rsel_w & byteenable_i[0]) begin
            rsel_reg <= writedata_i[iwwdt_pkg::RSEL_BIT];
         end
         if (wr_go_w & hit_slp_w & byteenable_i[0]) begin
            slpstp_reg <= writedata_i[iwwdt_pkg::SLPSTP_BIT];
         end
      end
   end

   // ==========================================================
   // Status flags: writing zero clears, a fresh event wins
   wire sts_wr_w = wr_go_w & hit_sts_w & byteenable_i[1];

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         uflow_flag_reg  <= 1'b0;
         referr_flag_reg <= 1'b0;
      end else begin
         uflow_flag_reg  <= underflow_w |
                            (uflow_flag_reg & ~(sts_wr_w & ~writedata_i[iwwdt_pkg::UFLOW_BIT]));
         referr_flag_reg <= refresh_err_w |
                            (referr_flag_reg & ~(sts_wr_w & ~writedata_i[iwwdt_pkg::REFERR_BIT]));
      end
   end

   // ==========================================================
   // Request and event outputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reset_req_o        <= 1'b0;
         irq_o              <= 1'b0;
         evt_underflow_o    <= 1'b0;
         evt_refresh_err_o  <= 1'b0;
         sleep_count_stop_o <= 1'b0;
      end else begin
         reset_req_o        <= fault_w & rsel_reg;
         irq_o              <= fault_w & ~rsel_reg;
         evt_underflow_o    <= underflow_w;
         evt_refresh_err_o  <= refresh_err_w;
         sleep_count_stop_o <= sleep_stop_w;
      end
   end

   // ==========================================================
   // Avalon-MM slave: one wait state, read data captured with it
   wire [31:0] rd_ctl_w  = {16'h0000, 2'b00, wstart_reg, 2'b00, wend_reg, div_sel_reg, 4'h0};
   wire [31:0] rd_sts_w  = {16'h0000, referr_flag_reg, uflow_flag_reg, count_reg};
   wire [31:0] rd_rsel_w = {24'h000000, rsel_reg, 7'h00};
   wire [31:0] rd_slp_w  = {24'h000000, slpstp_reg, 7'h00};
   wire [31:0] rd_opt_w  = {31'h00000000, auto_reg};
   wire [31:0] rd_mux_w  = hit_ctl_w  ? rd_ctl_w  :
                           hit_sts_w  ? rd_sts_w  :
                           hit_rsel_w ? rd_rsel_w :
                           hit_slp_w  ? rd_slp_w  :
                           hit_opt_w  ? rd_opt_w  : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         waitrequest_o <= 1'b1;
         readdata_o    <= 32'h00000000;
      end else if (bus_go_w) begin
         waitrequest_o <= 1'b1;
      end else if (read_i | write_i) begin
         waitrequest_o <= 1'b0;
         readdata_o    <= rd_mux_w;
      end else begin
         waitrequest_o <= 1'b1;
      end
   end

   // ==========================================================
   // Checks
   AST_DECREMENT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      dec_en_w && !fault_w && !refresh_hit_w |=> count_reg == $past(count_reg) - 14'h0001)
      else $error("Counter did not step down by one on a tick");

   AST_RESET_STATE: assert property (@(posedge mclk_i)
      sys_rst_i |=> count_reg == iwwdt_pkg::CNT_FULL && state_reg == iwwdt_pkg::ST_STOP && !reset_req_o)
      else $error("Reset did not restore the counter");

   AST_FAULT_STOP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      fault_w |=> state_reg == iwwdt_pkg::ST_STOP ##1 (state_reg == iwwdt_pkg::ST_RUN) == auto_reg)
      else $error("Counter not stopped or restarted wrongly after fault");

   AST_REG_START: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      state_reg == iwwdt_pkg::ST_STOP && !auto_reg && !refresh_hit_w |=> state_reg == iwwdt_pkg::ST_STOP)
      else $error("Register-start counter resumed without refresh");

   AST_AUTO_START: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) && auto_reg |=> state_reg == iwwdt_pkg::ST_RUN)
      else $error("Auto-start counter did not start after reset");

   AST_RESET_OUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      fault_w && rsel_reg |=> reset_req_o && !irq_o)
      else $error("Reset request missing after fault");

   AST_IRQ_OUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      fault_w && !rsel_reg |=> irq_o && !reset_req_o)
      else $error("Interrupt request missing after fault");

   AST_UFLOW_EVT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      running_w && cnt_tick_w && !sleep_stop_w && count_reg == 14'h0000 && !refresh_hit_w
      |=> evt_underflow_o && !evt_refresh_err_o)
      else $error("Underflow event not pulsed");

   AST_REFERR_FLAG: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      refresh_hit_w && running_w && !in_window_w |=> referr_flag_reg && evt_refresh_err_o)
      else $error("Refresh error not flagged");

   AST_BAD_SEQ: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_ref_w && wbyte_w != iwwdt_pkg::REFRESH_FIRST |=> !armed_reg)
      else $error("Broken refresh sequence left the block armed");

   AST_SLEEP_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      sleep_stop_w && !refresh_hit_w && running_w |=> $stable(count_reg) && sleep_count_stop_o)
      else $error("Counter moved while stopped for sleep");

   AST_TICK_SRC: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cnt_tick_w |-> $past(src_tick_reg))
      else $error("Counter tick without a source tick");

   AST_WIN_RELOAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      refresh_hit_w && running_w && in_window_w |=> running_w && count_reg == iwwdt_pkg::CNT_FULL)
      else $error("In-window refresh did not reload");

   AST_REG_REFRESH: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !running_w && refresh_hit_w |=> running_w && count_reg == iwwdt_pkg::CNT_FULL)
      else $error("Refresh did not start the counter");

   AST_AUTO_RESUME: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !running_w && auto_reg |=> running_w)
      else $error("Auto-start counter did not resume");

   AST_STATUS_READ: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      read_i && !waitrequest_o && hit_sts_w
      |-> readdata_o[15:0] == {$past(referr_flag_reg), $past(uflow_flag_reg), $past(count_reg)})
      else $error("Status read does not show the counter");

   AST_FAULT_CAUSE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reset_req_o || irq_o |-> $past(fault_w))
      else $error("Request output without a fault");

   AST_EVT_CAUSE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      evt_underflow_o || evt_refresh_err_o |-> $past(fault_w))
      else $error("Event pulse without a fault");

   AST_DIV_WRITE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_go_w && hit_ctl_w && byteenable_i[0] |=> div_sel_reg == $past(writedata_i[iwwdt_pkg::DIV_LSB +: 4]))
      else $error("Divide select not written");

   AST_WSTART_WRITE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_go_w && hit_ctl_w && byteenable_i[1] |=> wstart_reg == $past(writedata_i[iwwdt_pkg::WSTART_LSB +: 2]))
      else $error("Window start select not written");

   AST_RSEL_WRITE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_go_w && hit_rsel_w && byteenable_i[0] |=> rsel_reg == $past(writedata_i[iwwdt_pkg::RSEL_BIT]))
      else $error("Reset select not written");

   AST_ARM: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      wr_ref_w && wbyte_w == iwwdt_pkg::REFRESH_FIRST |=> armed_reg)
      else $error("First refresh byte did not arm");

   AST_SLEEP_OUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      sleep_stop_w |=> sleep_count_stop_o)
      else $error("Sleep stop output missing");

   AST_UFLOW_STOP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      underflow_w |=> uflow_flag_reg && !running_w)
      else $error("Underflow did not stop and flag");

endmodule
